// [pkg/fpt_pkg.sv]
/*
 * Constants shared by the flash program and erase timing sequencer.
 * Assumes a 10 MHz system clock and a tick enable pulse made from it.
 */
package fpt_pkg;

   // System clock rate and the default tick rate inside the allowed band.
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned TICK_HZ_DEFAULT = 400_000;
   localparam int unsigned TICK_DIV_DEFAULT = CLK_HZ / TICK_HZ_DEFAULT;

   // Fixed operation lengths in whole tick periods, and the last word index of a block.
   localparam logic [12:0] WORD_TICKS       = 13'd35;
   localparam logic [12:0] BLOCK_FIRST_TICKS = 13'd30;
   localparam logic [12:0] BLOCK_NEXT_TICKS = 13'd21;
   localparam logic [12:0] BLOCK_END_TICKS  = 13'd6;
   localparam logic [12:0] MASS_ERASE_TICKS = 13'd5297;
   localparam logic [12:0] SEG_ERASE_TICKS  = 13'd4819;
   localparam logic [5:0]  BLOCK_LAST_INDEX = 6'd63;

   // Commands presented on the command port.
   typedef enum logic [2:0] {
      FPT_CMD_NONE  = 3'h0,
      FPT_CMD_WORD  = 3'h1,
      FPT_CMD_BLOCK = 3'h2,
      FPT_CMD_SEG   = 3'h3,
      FPT_CMD_MASS  = 3'h4
   } fpt_cmd_e;

endpackage : fpt_pkg

// [logic/fpt_tick_div.sv]
/*
 * Tick divider: one-cycle enable pulse every div_in system clocks.
 * Assumes div_in is held steady while an operation runs.
 */
`timescale 1ns/1ps
module fpt_tick_div #(
   parameter int W = 8
) (
   input  wire logic         mclk_in,
   input  wire logic         rst_b_in,
   input  wire logic         run_in,
   input  wire logic [W-1:0] div_in,
   output logic             tick_out
);
   logic [W-1:0] cnt_r;

   // Counts down from div_in-1 while running and reloads at zero.
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_r <= '0;
      end else if (!run_in || (cnt_r == '0)) begin
         cnt_r <= div_in - W'(1);
      end else begin
         cnt_r <= cnt_r - W'(1);
      end
   end

   // The pulse is decoded, not registered, so the first tick lands exactly
   // div_in cycles after the run starts and an operation lasts whole periods.
   assign tick_out = run_in && (cnt_r == '0);
endmodule : fpt_tick_div

// [logic/fpt_seq.sv]
/*
 * Flash program and erase timing sequencer.
 * Assumes commands come from logic on mclk_in and the flash array
 * applies program or erase conditions while the matching strobe is high.
 */
`timescale 1ns/1ps
// How it works
// RQ1: a single word or byte program lasts 35 tick periods.
// RQ2: the first word of a block program takes 30 tick periods.
// RQ3: each further block word, up to index 63, takes 21 tick periods.
// RQ4: block programming ends with a 6 tick end-sequence wait.
// RQ5: mass erase holds the erase condition for 5297 tick periods.
// RQ6: segment erase lasts 4819 tick periods.
// RQ7: all counts are fixed constants; one unit is one tick period.
// RQ8: the host keeps the tick frequency within 257 to 476 kHz.
// RQ9: the host keeps cumulative programming per 64-byte block under 10 ms.
// RQ10: the host repeats mass erase, up to 19 times, to reach 200 ms.
// RQ11: busy is high from operation start to count expiry; commands then ignored.
module fpt_seq #(
   parameter int DIV_W = 8
) (
   input  wire logic             mclk_in,
   input  wire logic             rst_b_in,
   input  wire logic [DIV_W-1:0] tick_div_in,
   input  wire fpt_pkg::fpt_cmd_e cmd_in,
   input  wire logic             cmd_valid_in,
   input  wire logic             blk_more_in,
   output logic                  cmd_ready_out,
   output logic                  busy_out,
   output logic                  prog_out,
   output logic                  erase_out,
   output logic                  mass_out,
   output logic [5:0]            blk_index_out,
   output logic                  word_req_out,
   output logic                  done_out
);
   import fpt_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WORD, ST_BLK_FIRST, ST_BLK_NEXT, ST_BLK_END, ST_SEG, ST_MASS
   } fpt_state_e;

   fpt_state_e  state_r;
   logic [12:0] cnt_r;
   logic        tick;
   logic        last_tick;
   logic        blk_continue;

   // Tick enable pulse from the system clock; runs only while busy.
   fpt_tick_div #(.W(DIV_W)) u_div (
      .mclk_in  (mclk_in),
      .rst_b_in (rst_b_in),
      .run_in   (busy_out),
      .div_in   (tick_div_in),
      .tick_out (tick)
   );

   // Handshake and phase indications follow the state directly.
   assign busy_out      = (state_r != ST_IDLE);
   assign cmd_ready_out = !busy_out;                               // see RQ11
   assign last_tick     = tick && (cnt_r == 13'd1);
   assign blk_continue  = blk_more_in && (blk_index_out != BLOCK_LAST_INDEX);
   assign prog_out      = (state_r == ST_WORD) || (state_r == ST_BLK_FIRST)
                          || (state_r == ST_BLK_NEXT);
   assign erase_out     = (state_r == ST_SEG) || (state_r == ST_MASS);
   assign mass_out      = (state_r == ST_MASS);

   // Sequencer state and the fixed tick countdown of each phase.
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r <= ST_IDLE;
         cnt_r   <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (cmd_valid_in) begin                             // see RQ11
                  case (cmd_in)
                     FPT_CMD_WORD: begin
                        state_r <= ST_WORD;
                        cnt_r   <= WORD_TICKS;                     // see RQ1
                     end
                     FPT_CMD_BLOCK: begin
                        state_r <= ST_BLK_FIRST;
                        cnt_r   <= BLOCK_FIRST_TICKS;              // see RQ2
                     end
                     FPT_CMD_SEG: begin
                        state_r <= ST_SEG;
                        cnt_r   <= SEG_ERASE_TICKS;                // see RQ6
                     end
                     FPT_CMD_MASS: begin
                        state_r <= ST_MASS;
                        cnt_r   <= MASS_ERASE_TICKS;               // see RQ5
                     end
                     default: state_r <= ST_IDLE;
                  endcase
               end
            end
            ST_BLK_FIRST, ST_BLK_NEXT: begin
               if (last_tick && blk_continue) begin
                  state_r <= ST_BLK_NEXT;
                  cnt_r   <= BLOCK_NEXT_TICKS;                     // see RQ3
               end else if (last_tick) begin
                  state_r <= ST_BLK_END;
                  cnt_r   <= BLOCK_END_TICKS;                      // see RQ4
               end else if (tick) begin
                  cnt_r <= cnt_r - 13'd1;                          // see RQ7
               end
            end
            ST_WORD, ST_BLK_END, ST_SEG, ST_MASS: begin
               if (last_tick) begin
                  state_r <= ST_IDLE;                              // see RQ11
                  cnt_r   <= '0;
               end else if (tick) begin
                  cnt_r <= cnt_r - 13'd1;                          // see RQ7
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Word index inside the block and the request for the next word.
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         blk_index_out <= '0;
         word_req_out  <= 1'b0;
      end else begin
         word_req_out <= 1'b0;
         if (state_r == ST_IDLE) begin
            blk_index_out <= '0;
         end else if ((state_r == ST_BLK_FIRST || state_r == ST_BLK_NEXT)
                      && last_tick && blk_continue) begin
            blk_index_out <= blk_index_out + 6'd1;                 // see RQ3
            word_req_out  <= 1'b1;
         end
      end
   end

   // Completion pulse one cycle after an operation's count expires.
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= last_tick && (state_r == ST_WORD || state_r == ST_BLK_END
                                   || state_r == ST_SEG || state_r == ST_MASS);
      end
   end

   // Helper: count ticks spent in the current state for the checks below.
   logic [12:0] ticks_seen_r;
   fpt_state_e  prev_state_r;
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ticks_seen_r <= '0;
         prev_state_r <= ST_IDLE;
      end else begin
         prev_state_r <= state_r;
         if (state_r != prev_state_r) begin
            ticks_seen_r <= {12'd0, tick};
         end else if (tick) begin
            ticks_seen_r <= ticks_seen_r + 13'd1;
         end
      end
   end

   a_word_length: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see RQ1
      (state_r == ST_WORD && last_tick) |-> (ticks_seen_r == WORD_TICKS - 13'd1))
      else $error("Word program length is not 35 ticks.");
   a_blk_first: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see RQ2
      (state_r == ST_BLK_FIRST && last_tick) |-> (ticks_seen_r == BLOCK_FIRST_TICKS - 13'd1))
      else $error("First block word length is not 30 ticks.");
   a_blk_next: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see RQ3
      (state_r == ST_BLK_FIRST && last_tick && blk_continue)
      |=> (state_r == ST_BLK_NEXT && cnt_r == BLOCK_NEXT_TICKS))
      else $error("Further block word did not load 21 ticks.");
   a_blk_end: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see RQ4
      (state_r == ST_BLK_END && last_tick) |-> (ticks_seen_r == BLOCK_END_TICKS - 13'd1))
      else $error("Block end wait is not 6 ticks.");
   a_mass_len: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see RQ5
      (state_r == ST_MASS && last_tick) |-> (ticks_seen_r == MASS_ERASE_TICKS - 13'd1))
      else $error("Mass erase length is not 5297 ticks.");
   a_seg_len: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see RQ6
      (state_r == ST_SEG && last_tick) |-> (ticks_seen_r == SEG_ERASE_TICKS - 13'd1))
      else $error("Segment erase length is not 4819 ticks.");
   a_count_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see RQ7
      (busy_out && !tick && $stable(state_r)) |=> $stable(cnt_r))
      else $error("Count moved without a tick.");
   a_busy_ignore: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see RQ11
      (busy_out && !last_tick && cmd_valid_in) |=> busy_out && !cmd_ready_out)
      else $error("Command accepted while busy.");
   a_start_busy: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see RQ11
      (!busy_out && cmd_valid_in && cmd_in != FPT_CMD_NONE) |=> busy_out)
      else $error("Busy did not rise on a started operation.");

   c_word: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
      state_r == ST_WORD && last_tick);
   c_block_two: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
      state_r == ST_BLK_NEXT && last_tick);
   c_seg: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
      state_r == ST_SEG && last_tick);
   c_mass: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
      state_r == ST_MASS && last_tick);
endmodule : fpt_seq

// [dv/fpt_flash_model.sv]
/*
 * Flash array model for the far side of the timing sequencer.
 * Assumes words_in is held steady while a block program runs.
 */
`timescale 1ns/1ps
module fpt_flash_model (
   input  wire logic       mclk_in,
   input  wire logic       rst_b_in,
   input  wire logic       prog_in,
   input  wire logic       word_req_in,
   input  wire logic [6:0] words_in,
   output logic            blk_more_out
);
   logic [6:0] cnt_r;

   // Counts the further words requested since the program strobe rose.
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_r <= 7'h00;
      end else if (!prog_in) begin
         cnt_r <= 7'h00;
      end else if (word_req_in) begin
         cnt_r <= cnt_r + 7'h01;
      end
   end

   // Asks for more words until the wanted count is reached; idles high.
   assign blk_more_out = prog_in ? ((cnt_r + 7'h01) < words_in) : 1'b1;
endmodule : fpt_flash_model

// [dv/tb.sv]
/*
 * Self-checking bench for the timing sequencer: a table of operations,
 * then refusal, back-to-back and reset cases. Assumes the flash model.
 */
`timescale 1ns/1ps
module tb;
   import fpt_pkg::*;
   typedef struct {fpt_cmd_e c; int d; int w; int len; int act; int idx;} fpt_row_s;
   logic       mclk = 0, rst_b = 0, cvalid = 0, ready, busy, prog, erase, mass, wreq, done, more;
   logic [7:0] div = 8'h01;
   fpt_cmd_e   cmd = FPT_CMD_NONE;
   logic [5:0] idx;
   logic [6:0] words = 7'h01;
   int         errors = 0, n_checks = 0, cyc = 0, n, a, im, q;
   logic [2:0] f;
   fpt_row_s   rows[8] = '{'{FPT_CMD_WORD, 2, 1, 70, 70, 0}, '{FPT_CMD_WORD, 25, 1, 875, 875, 0},
      '{FPT_CMD_BLOCK, 2, 1, 72, 60, 0}, '{FPT_CMD_BLOCK, 1, 3, 78, 72, 2},
      '{FPT_CMD_BLOCK, 1, 64, 1359, 1353, 63}, '{FPT_CMD_SEG, 1, 1, 4819, 4819, 0},
      '{FPT_CMD_MASS, 1, 1, 5297, 5297, 0}, '{FPT_CMD_NONE, 1, 1, 0, 0, 0}};

   fpt_seq dut (.mclk_in(mclk), .rst_b_in(rst_b), .tick_div_in(div), .cmd_in(cmd),
      .cmd_valid_in(cvalid), .blk_more_in(more), .cmd_ready_out(ready), .busy_out(busy),
      .prog_out(prog), .erase_out(erase), .mass_out(mass), .blk_index_out(idx),
      .word_req_out(wreq), .done_out(done));
   fpt_flash_model fm (.mclk_in(mclk), .rst_b_in(rst_b), .prog_in(prog),
      .word_req_in(wreq), .words_in(words), .blk_more_out(more));

   // Makes the 10 MHz clock.
   always #50 mclk = ~mclk;

   task chk(input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("Error t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task tally_and_finish;
      if (errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // Presents a command; returns just after the edge that takes it.
   task issue(input fpt_cmd_e c, input int d);
      @(posedge mclk) div <= d[7:0];
      cmd <= c;
      cvalid <= 1'b1;
      @(posedge mclk) cvalid <= 1'b0;
   endtask : issue

   // Counts busy cycles, strobe cycles, top index and word requests.
   task meas;
      n = 0; a = 0; im = 0; q = 0; f = 3'h0;
      #1;
      while (busy === 1'b1 && n < 6000) begin
         if (n == 0) f = {prog, erase, mass};
         n++;
         a += int'(prog | erase);
         if (int'(idx) > im) im = int'(idx);
         q += int'(wreq);
         @(posedge mclk) #1;
      end
   endtask : meas

   // Cuts a hang short.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         tally_and_finish;
      end
   end

   initial begin
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         words = rows[i].w[6:0];
         issue(rows[i].c, rows[i].d);
         meas;
         chk(n, rows[i].len);
         chk(a, rows[i].act);
         chk(im, rows[i].idx);
         chk(q, rows[i].idx);
         chk(f, {rows[i].c inside {FPT_CMD_WORD, FPT_CMD_BLOCK},
            rows[i].c inside {FPT_CMD_SEG, FPT_CMD_MASS}, rows[i].c == FPT_CMD_MASS});
         if (rows[i].len > 0) begin
            chk(done, 1);
            @(posedge mclk) #1;
            chk(done, 0);
         end
      end
      // Mass erase is reissued at once, as a host does to build up erase time.
      issue(FPT_CMD_MASS, 1);
      meas;
      chk(n, 5297);
      chk(done, 1);
      // A word request held through a block program is refused, then taken back to back.
      words = 7'h01;
      @(posedge mclk) div <= 8'h02;
      cmd <= FPT_CMD_BLOCK;
      cvalid <= 1'b1;
      @(posedge mclk) cmd <= FPT_CMD_WORD;
      meas;
      chk(n, 72);
      chk({done, ready}, 2'h3);
      @(posedge mclk) cvalid <= 1'b0;
      #1 chk({done, busy}, 2'h1);
      meas;
      chk(n, 70);
      // Reset in mid erase clears every output but ready, which reads high.
      issue(FPT_CMD_MASS, 1);
      repeat (100) @(posedge mclk);
      rst_b <= 1'b0;
      @(posedge mclk) #1;
      chk({busy, ready, prog, erase, mass, idx, wreq, done}, 16'h0800);
      rst_b <= 1'b1;
      issue(FPT_CMD_WORD, 1);
      meas;
      chk(n, 35);
      tally_and_finish;
   end
endmodule : tb
